/* File: include/smm_consts.svh */
/*
 Constants of the status monitor multiplexer: register indices, field
 positions, reset values, selector codes and interrupt event bits.
 Assumes a 32-bit Wishbone slave where byte address = index * 4.
*/
`ifndef SMM_CONSTS_SVH
`define SMM_CONSTS_SVH

// register indices (byte address is four times the index)
`define SMM_IDX_SEL_ZERO    14'h0505
`define SMM_IDX_SEL_ONE     14'h0506
`define SMM_IDX_PIN_CTRL    14'h0507
`define SMM_IDX_IRQ_STAT    14'h0510
`define SMM_IDX_IRQ_MASK    14'h0511
`define SMM_IDX_LIVE        14'h0512

// selector field inside a selector register
`define SMM_SEL_MSB         5
`define SMM_SEL_LSB         0

// pin control register fields
`define SMM_PC_EN_ONE       3
`define SMM_PC_EN_ZERO      2
`define SMM_PC_DIV_ZERO     1
`define SMM_PC_DIV_ONE      0

// first code of the halved-clock group of each monitor
`define SMM_CODE_HALF_ZERO  6'h10
`define SMM_CODE_HALF_ONE   6'h14

// interrupt event bits
`define SMM_EV_CLEANUP_UNLOCK 0
`define SMM_EV_SYNTH_UNLOCK   1
`define SMM_EV_REFS_MISSING   2
`define SMM_EV_HOLDOVER       3

// reset values
`define SMM_RST_SEL         8'h00
`define SMM_RST_PIN_CTRL    4'h0
`define SMM_RST_IRQ_MASK    4'h0
`define SMM_RST_IRQ_STAT    4'h0
`define SMM_RST_EV_PREV     4'hf

`endif

/* File: include/smm_pkg.sv */
/*
 Types of the status monitor multiplexer: bus request, condition inputs,
 loop clock samples and the state records of both modules.
 Assumes the constants header is included by the modules that use it.
*/
package smm_pkg;

    // classic wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [15:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } smm_wb_req_s;

    // static conditions reported by the loops and reference monitors
    typedef struct packed {
        logic cleanup_loop_locked;
        logic synth_loop_locked;
        logic reference_a_missing;
        logic reference_b_missing;
        logic reference_b_active;
        logic auto_select_mode;
        logic reference_a_valid;
        logic reference_b_valid;
        logic cleanup_loop_holdover;
        logic external_oscillator_valid;
        logic cleanup_loop_fb_valid;
        logic synth_loop_fb_valid;
        logic fast_lock_busy;
    } smm_cond_s;

    // sampled loop clocks, synchronous to clk_i
    typedef struct packed {
        logic cleanup_fb;
        logic cleanup_pd_down;
        logic cleanup_ref;
        logic cleanup_pd_up;
        logic synth_fb;
        logic synth_pd_down;
        logic synth_ref;
        logic synth_pd_up;
    } smm_loop_clk_s;

    // state of the top module
    typedef struct packed {
        logic [7:0]  sel_zero;
        logic [7:0]  sel_one;
        logic [3:0]  pin_ctrl;
        logic [3:0]  irq_mask;
        logic [3:0]  irq_stat;
        logic        irq;
        logic        ack;
        logic [31:0] rdata;
        logic [3:0]  ev_prev;
        logic [7:0]  clk_prev;
        logic [7:0]  half;
    } smm_state_s;

    // state of one monitor channel
    typedef struct packed {
        logic       mux_prev;
        logic [1:0] div_cnt;
        logic       pin;
        logic       oe;
    } smm_chan_state_s;

endpackage

/* File: src/smm_chan.sv */
/*
 One status monitor channel: selector multiplexer, optional divide by four
 and the registered pin driver.
 Assumes selector and control come from registers in the same clock domain.
*/
`timescale 1ns/1ps
`include "smm_consts.svh"

module smm_chan #(
    parameter logic [5:0] HALF_BASE = `SMM_CODE_HALF_ZERO
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [5:0]  sel_i,
    input  wire logic [15:0] static_i,
    input  wire logic [3:0]  half_i,
    input  wire logic        en_i,
    input  wire logic        div_en_i,
    output logic             pin_o,
    output logic             oe_o
);

    smm_pkg::smm_chan_state_s cur_reg;
    smm_pkg::smm_chan_state_s cur_next;
    logic                     mux_val;

    // selector decode, divider and pin value
    always_comb begin
        cur_next = cur_reg;
        mux_val  = 1'b0;
        if (sel_i[5:4] == 2'h0) begin
            mux_val = static_i[sel_i[3:0]];
        end else if (sel_i[5:2] == HALF_BASE[5:2]) begin
            mux_val = half_i[sel_i[1:0]];
        end
        cur_next.mux_prev = mux_val;
        if (mux_val && !cur_reg.mux_prev) begin
            cur_next.div_cnt = cur_reg.div_cnt + 2'h1;
        end
        cur_next.pin = en_i & (div_en_i ? cur_reg.div_cnt[1] : mux_val);
        cur_next.oe  = en_i;
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign pin_o = cur_reg.pin;
    assign oe_o  = cur_reg.oe;

endmodule // smm_chan

/* File: src/smm_top.sv */
/*
 Status monitor multiplexer pair with its Wishbone register file and an
 interrupt for loop and reference events.
 Assumes all condition and loop clock inputs are synchronous to clk_i;
 the loop clocks must be well below half the clk_i rate to be halved.
*/
// How it works
// - Register zero holds an 8-bit selector; low six bits choose status output zero.
// - Register one holds an 8-bit selector for status output one, same static codes 0-15.
// - Codes 0-3: output low, both loops locked, cleanup locked, synth locked.
// - Code 4: both references missing; code 5: both missing and synth loop locked.
// - Code 6: reference b active, shown only in automatic selection mode.
// - Codes 7, 8, 14: reference a valid, reference b valid, both valid.
// - Code 9: cleanup loop in holdover; code 13: fast lock in progress.
// - Codes 10-12: oscillator valid, cleanup feedback valid, synth feedback valid.
// - Code 15: asserted only when all monitored clocks are valid together.
// - Monitor zero codes 16-19 give halved cleanup clocks; 20-23 low.
// - Monitor one codes 16-19 low; 20, 21 halved synth feedback and down.
// - Monitor one codes 22, 23 halved synth reference and up; higher reserved.
// - Each pin shows its condition only while its output enable bit is set.
// - Optional divide by four per pin; software avoids it for static codes.
`timescale 1ns/1ps
`include "smm_consts.svh"

module smm_top (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire smm_pkg::smm_wb_req_s  wb_req_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    input  wire smm_pkg::smm_cond_s    cond_i,
    input  wire smm_pkg::smm_loop_clk_s loop_clk_i,
    output logic                       status_out_zero_o,
    output logic                       status_oe_zero_o,
    output logic                       status_out_one_o,
    output logic                       status_oe_one_o,
    output logic                       irq_o
);

    smm_pkg::smm_state_s st_reg;
    smm_pkg::smm_state_s st_next;

    logic [7:0]  clk_v;
    logic [15:0] static_v;
    logic [3:0]  ev_now;
    logic [3:0]  ev_rise;
    logic [3:0]  irq_clr;
    logic        access;
    logic        wr_lane0;
    logic [13:0] idx;
    logic        pin_zero;
    logic        oe_zero;
    logic        pin_one;
    logic        oe_one;

    // loop clocks in code order: bit = loop * 4 + offset within group
    assign clk_v = {loop_clk_i.synth_pd_up,   loop_clk_i.synth_ref,
                    loop_clk_i.synth_pd_down, loop_clk_i.synth_fb,
                    loop_clk_i.cleanup_pd_up, loop_clk_i.cleanup_ref,
                    loop_clk_i.cleanup_pd_down, loop_clk_i.cleanup_fb};

    // static condition table, indexed by the low four selector bits
    always_comb begin
        static_v     = 16'h0000;
        static_v[1]  = cond_i.cleanup_loop_locked & cond_i.synth_loop_locked;
        static_v[2]  = cond_i.cleanup_loop_locked;
        static_v[3]  = cond_i.synth_loop_locked;
        static_v[4]  = cond_i.reference_a_missing & cond_i.reference_b_missing;
        static_v[5]  = cond_i.reference_a_missing & cond_i.reference_b_missing
                     & cond_i.synth_loop_locked;
        static_v[6]  = cond_i.reference_b_active & cond_i.auto_select_mode;
        static_v[7]  = cond_i.reference_a_valid;
        static_v[8]  = cond_i.reference_b_valid;
        static_v[9]  = cond_i.cleanup_loop_holdover;
        static_v[10] = cond_i.external_oscillator_valid;
        static_v[11] = cond_i.cleanup_loop_fb_valid;
        static_v[12] = cond_i.synth_loop_fb_valid;
        static_v[13] = cond_i.fast_lock_busy;
        static_v[14] = cond_i.reference_a_valid & cond_i.reference_b_valid;
        static_v[15] = cond_i.reference_a_valid & cond_i.reference_b_valid
                     & cond_i.external_oscillator_valid
                     & cond_i.cleanup_loop_fb_valid
                     & cond_i.synth_loop_fb_valid;
    end

    // events watched by the interrupt logic
    assign ev_now = {cond_i.cleanup_loop_holdover,
                     cond_i.reference_a_missing & cond_i.reference_b_missing,
                     ~cond_i.synth_loop_locked,
                     ~cond_i.cleanup_loop_locked};
    assign ev_rise = ev_now & ~st_reg.ev_prev;

    // bus request decode: one access per request, answered by ack
    assign access   = wb_req_i.cyc & wb_req_i.stb & ~st_reg.ack;
    assign wr_lane0 = access & wb_req_i.we & wb_req_i.sel[0];
    assign idx      = wb_req_i.adr[15:2];

    // write one to clear, only through byte lane zero
    always_comb begin
        irq_clr = 4'h0;
        if (wr_lane0 && idx == `SMM_IDX_IRQ_STAT) begin
            irq_clr = wb_req_i.dat[3:0];
        end
    end

    // next state: registers, halving dividers, events and bus answer
    always_comb begin
        st_next = st_reg;

        // halved loop clocks: toggle on each rising edge of the sample
        st_next.clk_prev = clk_v;
        st_next.half     = st_reg.half ^ (clk_v & ~st_reg.clk_prev);

        // register writes take effect at the edge that raises ack
        if (wr_lane0) begin
            if (idx == `SMM_IDX_SEL_ZERO) begin
                st_next.sel_zero = wb_req_i.dat[7:0];
            end else if (idx == `SMM_IDX_SEL_ONE) begin
                st_next.sel_one = wb_req_i.dat[7:0];
            end else if (idx == `SMM_IDX_PIN_CTRL) begin
                st_next.pin_ctrl = wb_req_i.dat[3:0];
            end else if (idx == `SMM_IDX_IRQ_MASK) begin
                st_next.irq_mask = wb_req_i.dat[3:0];
            end
        end

        // sticky status: a new event wins over a clear in the same cycle
        st_next.ev_prev  = ev_now;
        st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | ev_rise;
        st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

        // answer one cycle after the request, drop ack the cycle after
        st_next.ack = access;
        if (access && !wb_req_i.we) begin
            if (idx == `SMM_IDX_SEL_ZERO) begin
                st_next.rdata = {24'h000000, st_reg.sel_zero};
            end else if (idx == `SMM_IDX_SEL_ONE) begin
                st_next.rdata = {24'h000000, st_reg.sel_one};
            end else if (idx == `SMM_IDX_PIN_CTRL) begin
                st_next.rdata = {28'h0000000, st_reg.pin_ctrl};
            end else if (idx == `SMM_IDX_IRQ_STAT) begin
                st_next.rdata = {28'h0000000, st_reg.irq_stat};
            end else if (idx == `SMM_IDX_IRQ_MASK) begin
                st_next.rdata = {28'h0000000, st_reg.irq_mask};
            end else if (idx == `SMM_IDX_LIVE) begin
                st_next.rdata = {17'h00000, pin_one, pin_zero, cond_i};
            end else begin
                st_next.rdata = 32'h00000000;              // unmapped reads zero
            end
        end else if (access) begin
            st_next.rdata = 32'h00000000;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg          <= '0;
            st_reg.sel_zero <= `SMM_RST_SEL;
            st_reg.sel_one  <= `SMM_RST_SEL;
            st_reg.pin_ctrl <= `SMM_RST_PIN_CTRL;
            st_reg.irq_mask <= `SMM_RST_IRQ_MASK;
            st_reg.irq_stat <= `SMM_RST_IRQ_STAT;
            st_reg.ev_prev  <= `SMM_RST_EV_PREV;
        end else begin
            st_reg <= st_next;
        end
    end

    // monitor zero: halved cleanup loop clocks at its half group
    smm_chan #(
        .HALF_BASE (`SMM_CODE_HALF_ZERO)
    ) u_chan_zero (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sel_i    (st_reg.sel_zero[`SMM_SEL_MSB:`SMM_SEL_LSB]),
        .static_i (static_v),
        .half_i   (st_reg.half[3:0]),
        .en_i     (st_reg.pin_ctrl[`SMM_PC_EN_ZERO]),
        .div_en_i (st_reg.pin_ctrl[`SMM_PC_DIV_ZERO]),
        .pin_o    (pin_zero),
        .oe_o     (oe_zero)
    );

    // monitor one: halved synth loop clocks at its half group
    smm_chan #(
        .HALF_BASE (`SMM_CODE_HALF_ONE)
    ) u_chan_one (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .sel_i    (st_reg.sel_one[`SMM_SEL_MSB:`SMM_SEL_LSB]),
        .static_i (static_v),
        .half_i   (st_reg.half[7:4]),
        .en_i     (st_reg.pin_ctrl[`SMM_PC_EN_ONE]),
        .div_en_i (st_reg.pin_ctrl[`SMM_PC_DIV_ONE]),
        .pin_o    (pin_one),
        .oe_o     (oe_one)
    );

    // outputs straight from flip-flops
    assign wb_dat_o          = st_reg.rdata;
    assign wb_ack_o          = st_reg.ack;
    assign irq_o             = st_reg.irq;
    assign status_out_zero_o = pin_zero;
    assign status_oe_zero_o  = oe_zero;
    assign status_out_one_o  = pin_one;
    assign status_oe_one_o   = oe_one;

endmodule // smm_top

/* File: testbench/smm_top_asserts.sv */
/*
 Port checker of the status monitor pair: bus answer, pin enables, code map.
 Assumes it is bound onto smm_top and sees only its ports; one clock domain.
*/
`timescale 1ns/1ps
`include "smm_consts.svh"
module smm_top_asserts (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire smm_pkg::smm_wb_req_s wb_req_i,
    input  wire logic                 wb_ack_o,
    input  wire smm_pkg::smm_cond_s   cond_i,
    input  wire logic                 status_out_zero_o,
    input  wire logic                 status_oe_zero_o,
    input  wire logic                 status_out_one_o,
    input  wire logic                 status_oe_one_o
);
    logic [7:0] sh0_reg;
    logic [7:0] sh1_reg;
    logic [3:0] pc_reg;
    logic       wr;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a write that the slave takes at this edge
    assign wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_req_i.sel[0] && !wb_ack_o;
    // shadow copies of both selectors and the pin control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh0_reg <= 8'h00;
            sh1_reg <= 8'h00;
            pc_reg  <= 4'h0;
        end else if (wr) begin
            if (wb_req_i.adr[15:2] == `SMM_IDX_SEL_ZERO) sh0_reg <= wb_req_i.dat[7:0];
            if (wb_req_i.adr[15:2] == `SMM_IDX_SEL_ONE) sh1_reg <= wb_req_i.dat[7:0];
            if (wb_req_i.adr[15:2] == `SMM_IDX_PIN_CTRL) pc_reg <= wb_req_i.dat[3:0];
        end
    end
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
    property p_ack_cause; wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("request not answered");
    property p_off_zero; !status_oe_zero_o |-> !status_out_zero_o; endproperty
    a_off_zero: assert property (p_off_zero) else $error("pin zero driven while off");
    property p_off_one; !status_oe_one_o |-> !status_out_one_o; endproperty
    a_off_one: assert property (p_off_one) else $error("pin one driven while off");
    property p_gnd; sh0_reg[5:0] == 6'h00 && !pc_reg[1] |=> !status_out_zero_o; endproperty
    a_gnd: assert property (p_gnd) else $error("code zero not low");
    property p_lock;
        sh0_reg[5:0] == 6'h01 && pc_reg[2] && !pc_reg[1] |=>
            status_out_zero_o == ($past(cond_i.cleanup_loop_locked) && $past(cond_i.synth_loop_locked));
    endproperty
    a_lock: assert property (p_lock) else $error("both locked code wrong");
    property p_res; sh0_reg[5:0] >= 6'h18 && !pc_reg[1] |=> !status_out_zero_o; endproperty
    a_res: assert property (p_res) else $error("reserved code not low");
    property p_all;
        sh1_reg[5:0] == 6'h0f && pc_reg[3] && !pc_reg[0] |=>
            status_out_one_o == ($past(cond_i.reference_a_valid) && $past(cond_i.reference_b_valid)
            && $past(cond_i.external_oscillator_valid) && $past(cond_i.cleanup_loop_fb_valid)
            && $past(cond_i.synth_loop_fb_valid));
    endproperty
    a_all: assert property (p_all) else $error("all clocks code wrong");
    property p_low_one; sh1_reg[5:2] == 4'h4 && !pc_reg[0] |=> !status_out_one_o; endproperty
    a_low_one: assert property (p_low_one) else $error("monitor one low codes driven");
endmodule // smm_top_asserts

bind smm_top smm_top_asserts chk_u (.clk_i, .rst_i, .wb_req_i, .wb_ack_o, .cond_i, .status_out_zero_o,
    .status_oe_zero_o, .status_out_one_o, .status_oe_one_o);

/* File: testbench/smm_mon.sv */
/*
 Far side model: logic that watches both status pins and counts rises.
 Assumes pins and enables change only on clk_i.
*/
`timescale 1ns/1ps
module smm_mon (
    input  wire logic clk_i,
    input  wire logic pin0_i,
    input  wire logic oe0_i,
    input  wire logic pin1_i,
    input  wire logic oe1_i,
    output int        rise0_o,
    output int        rise1_o
);
    logic prev0;
    logic prev1;
    // a pin is seen only while its driver is enabled
    always @(posedge clk_i) begin
        prev0 <= pin0_i && oe0_i;
        prev1 <= pin1_i && oe1_i;
        if (pin0_i && oe0_i && prev0 === 1'b0) rise0_o <= rise0_o + 1;
        if (pin1_i && oe1_i && prev1 === 1'b0) rise1_o <= rise1_o + 1;
    end
endmodule // smm_mon

/* File: testbench/smm_top_tb_top.sv */
/*
 Testbench of the status monitor pair: registers, code map, halved clocks, irq.
 Assumes smm_top, its checker and the pin watcher are compiled before it.
*/
`timescale 1ns/1ps
`include "smm_consts.svh"
module smm_top_tb_top;
    logic                   clk_i;
    logic                   rst_i;
    smm_pkg::smm_wb_req_s   req;
    smm_pkg::smm_cond_s     cond;
    smm_pkg::smm_loop_clk_s lclk;
    logic [31:0]            rdat;
    logic [31:0]            q;
    logic                   ack, o0, e0, o1, e1, irq;
    int                     r0, r1, n0, n1, a, k, bad_count, checked;
    smm_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cond_i(cond), .loop_clk_i(lclk), .status_out_zero_o(o0), .status_oe_zero_o(e0),
        .status_out_one_o(o1), .status_oe_one_o(e1), .irq_o(irq));
    smm_mon mon_u (.clk_i(clk_i), .pin0_i(o0), .oe0_i(e0), .pin1_i(o1), .oe1_i(e1), .rise0_o(n0), .rise1_o(n1));
    // free running clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one classic cycle; read data lands in q
    task automatic wb(input logic we, input logic [13:0] idx, input logic [7:0] d);
        int n;
        req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h0, d}};
        n = 0;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            n++;
            if (n > 20) begin
                bad_count++;
                conclude;
            end
            @(posedge clk_i);
        end
        q = rdat;
        req <= '0;
        @(posedge clk_i);
    endtask
    // static level of a code; bit order of the condition record, msb first
    function automatic logic lvl(input int c, input logic [12:0] v);
        case (c)
            1: return v[12] & v[11];
            2: return v[12];
            3: return v[11];
            4: return v[10] & v[9];
            5: return v[10] & v[9] & v[11];
            6: return v[8] & v[7];
            7: return v[6];
            8: return v[5];
            9: return v[4];
            10: return v[3];
            11: return v[2];
            12: return v[1];
            13: return v[0];
            14: return v[6] & v[5];
            15: return v[6] & v[5] & v[3] & v[2] & v[1];
            default: return 1'b0;
        endcase
    endfunction
    initial begin
        req = '0;
        cond = '0;
        lclk = '0;
        rst_i = 1'b1;
        bad_count = 0;
        checked = 0;
        a = $urandom(32'h423124d9);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, an unmapped read, read back with top bits
        wb(0, `SMM_IDX_SEL_ZERO, 0); chk(q, 0);
        wb(0, `SMM_IDX_SEL_ONE, 0); chk(q, 0);
        wb(0, 14'h0100, 0); chk(q, 0);
        chk({e0, o0, e1, o1}, 0);
        wb(1, `SMM_IDX_SEL_ONE, 8'hc5); wb(0, `SMM_IDX_SEL_ONE, 0); chk(q, 32'hc5);
        wb(1, `SMM_IDX_PIN_CTRL, 8'h0c);
        // every code on both pins, random top bits and conditions
        for (a = 0; a < 64; a++) begin
            wb(1, `SMM_IDX_SEL_ZERO, {2'($urandom), 6'(a)});
            wb(1, `SMM_IDX_SEL_ONE, {2'($urandom), 6'(a)});
            for (k = 0; k < 4; k++) begin
                cond <= (k == 0) ? '1 : (k == 1) ? '0 : 13'($urandom);
                repeat (2) @(posedge clk_i);
                chk(o0, lvl(a, cond));
                chk(o1, lvl(a, cond));
            end
        end
        // halved loop clocks, plain and divided by four
        for (a = 0; a < 4; a++) begin
            wb(1, `SMM_IDX_PIN_CTRL, {6'h03, a[0], a[0]});
            wb(1, `SMM_IDX_SEL_ZERO, 8'h10 + 8'(a));
            wb(1, `SMM_IDX_SEL_ONE, 8'h14 + 8'(a));
            repeat (4) @(posedge clk_i);
            r0 = n0;
            r1 = n1;
            repeat (32) begin
                // only the clock pair under test moves, so a swapped mux input gives no rises
                lclk <= smm_pkg::smm_loop_clk_s'(lclk ^ (8'h88 >> a));
                repeat (2) @(posedge clk_i);
            end
            repeat (6) @(posedge clk_i);
            chk(n0 - r0, a[0] ? 2 : 8);
            chk(n1 - r1, a[0] ? 2 : 8);
        end
        // only pin zero enabled
        wb(1, `SMM_IDX_PIN_CTRL, 8'h04);
        wb(1, `SMM_IDX_SEL_ZERO, 8'h01);
        wb(1, `SMM_IDX_SEL_ONE, 8'h01);
        cond <= '1;
        repeat (2) @(posedge clk_i);
        chk({e0, o0, e1, o1}, 4'b1100);
        // live view: pin one off, pin zero high, all conditions true
        wb(0, `SMM_IDX_LIVE, 0); chk(q, {17'h00000, 2'b01, 13'h1fff});
        // lock loss event: masked, unmasked, cleared
        wb(1, `SMM_IDX_IRQ_STAT, 8'h0f);
        wb(1, `SMM_IDX_IRQ_MASK, 8'h02);
        cond.cleanup_loop_locked <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(irq, 0);
        wb(0, `SMM_IDX_IRQ_STAT, 0); chk(q, 1);
        wb(1, `SMM_IDX_IRQ_MASK, 8'h01);
        @(posedge clk_i);
        chk(irq, 1);
        wb(1, `SMM_IDX_IRQ_STAT, 8'h01);
        @(posedge clk_i);
        chk(irq, 0);
        wb(0, `SMM_IDX_IRQ_STAT, 0); chk(q, 0);
        conclude;
    end
endmodule // smm_top_tb_top
